// ---- src/hbsl_status_link.sv ----
// Status word encoder, line controller, gate gating and APB registers
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module hbsl_status_link #(
    parameter bit PARITY_ODD = 1'b0
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    // Fault monitors
    input  wire logic        busOvAbove,
    input  wire logic        busOvBelowHyst,
    input  wire logic [3:0]  busUndervoltage,
    input  wire logic        systemSenseIn,
    input  wire logic        lowSideSupplyPinFault,
    input  wire logic        senseShortFault,
    input  wire logic        trimFault,
    input  wire logic        highSideCommLoss,
    input  wire logic        highSideBypassSupplyFault,
    input  wire logic        highSideSupplyPinFault,
    input  wire logic        lowSideThermWarn,
    input  wire logic        lowSideThermShut,
    input  wire logic        lowSideOverCurrent,
    input  wire logic        highSideOverCurrent,
    // Controller gate inputs
    input  wire logic        lowGateInPhaseA,
    input  wire logic        lowGateInPhaseB,
    input  wire logic        highGateInNPhaseA,
    input  wire logic        highGateInNPhaseB,
    // Gate drive, active high
    output logic             lowGateOnPhaseA,
    output logic             lowGateOnPhaseB,
    output logic             highGateOnPhaseA,
    output logic             highGateOnPhaseB,
    // Open-drain status line
    input  wire logic        faultLineIn,
    output logic             faultLineOut,
    output logic             faultLineOe
);

    typedef struct packed {
        logic [6:0]  tickCnt;
        logic        tick;
        logic [2:0]  ctrl;
        logic [2:0]  irqStat;
        logic [2:0]  irqMask;
        logic        irq;
        logic        ovLatched;
        logic [7:0]  word;
        logic [7:0]  lastWord;
        logic        sendPending;
        logic [3:0]  reqCnt;
        logic [3:0]  gates;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        lineOut;
    } hbsl_top_s;

    hbsl_top_s s;
    hbsl_top_s next_s;

    logic       serStart;
    logic       serBusy;
    logic       serDone;
    logic       serOe;
    logic       hostLow;
    logic       reqEvent;
    logic       chgEvent;
    logic       apbAccess;
    logic [2:0] clrMask;
    logic [2:0] evMask;
    logic [2:0] field0;
    logic [1:0] field1;
    logic [6:0] status7;
    logic       allow;
    logic       lsOn;
    logic       hsOn;

    // ==============================================================
    // Serialiser
    hbsl_word_tx u_tx (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (s.tick),
        .start   (serStart),
        .frame   (s.word),
        .lineOe  (serOe),
        .busy    (serBusy),
        .done    (serDone)
    );

    // ==============================================================
    // Word encoder
    always_comb begin
        // Fixed order only matters if the exclusive conditions overlap
        if (s.ovLatched) begin
            field0 = hbsl_pkg::CODE_OV;
        end else if (lowSideSupplyPinFault || senseShortFault
                     || trimFault) begin
            field0 = hbsl_pkg::CODE_LS_NRDY;
        end else if (systemSenseIn) begin
            field0 = hbsl_pkg::CODE_SYS_OT;
        end else if (busUndervoltage[3]) begin
            field0 = hbsl_pkg::CODE_UV55;
        end else if (busUndervoltage[2]) begin
            field0 = hbsl_pkg::CODE_UV70;
        end else if (busUndervoltage[1]) begin
            field0 = hbsl_pkg::CODE_UV85;
        end else if (busUndervoltage[0]) begin
            field0 = hbsl_pkg::CODE_UV100;
        end else begin
            field0 = hbsl_pkg::CODE_NONE;
        end
        if (highSideCommLoss || highSideBypassSupplyFault
            || highSideSupplyPinFault) begin
            field1 = hbsl_pkg::CODE_HS_NRDY;
        end else if (lowSideThermShut) begin
            field1 = hbsl_pkg::CODE_SHUT;
        end else if (lowSideThermWarn) begin
            field1 = hbsl_pkg::CODE_WARN;
        end else begin
            field1 = 2'h0;
        end
        // Bit 0 in the lsb, so it leaves the line first
        status7 = {highSideOverCurrent, lowSideOverCurrent,
                   field1, field0};
    end

    // ==============================================================
    // Gate gating
    always_comb begin
        allow = s.ctrl[hbsl_pkg::CTRL_SW_EN] && !s.ovLatched;
    end

    // ==============================================================
    // Line control, events and APB
    always_comb begin
        next_s = s;
        // Divider for the line tick
        next_s.tick = 1'b0;
        if (s.tickCnt == hbsl_pkg::TICK_CNT_MAX) begin
            next_s.tickCnt = 7'h00;
            next_s.tick    = 1'b1;
        end else begin
            next_s.tickCnt = s.tickCnt + 7'h01;
        end
        // Overvoltage latch with hysteresis release
        if (busOvAbove) begin
            next_s.ovLatched = 1'b1;
        end else if (busOvBelowHyst) begin
            next_s.ovLatched = 1'b0;
        end
        next_s.word = {PARITY_ODD ^ (^status7), status7};
        // Our own release must not look like a request
        hostLow  = !faultLineIn && !serOe && !serBusy;
        reqEvent = 1'b0;
        if (hostLow) begin
            if (s.tick && s.reqCnt != hbsl_pkg::REQ_TICKS) begin
                next_s.reqCnt = s.reqCnt + 4'h1;
            end
        end else begin
            reqEvent      = (s.reqCnt == hbsl_pkg::REQ_TICKS);
            next_s.reqCnt = 4'h0;
        end
        // A frame waits for an idle, released line
        serStart = s.sendPending && s.ctrl[hbsl_pkg::CTRL_LINK_EN]
                   && !serBusy && faultLineIn && (s.reqCnt == 4'h0);
        chgEvent = (s.word != s.lastWord) && !serStart;
        if (serStart) begin
            next_s.lastWord = s.word;
        end
        // Set wins over the clear on the same edge
        next_s.sendPending = (s.sendPending && !serStart) || chgEvent
                             || reqEvent
                             || s.ctrl[hbsl_pkg::CTRL_FORCE];
        next_s.ctrl[hbsl_pkg::CTRL_FORCE] = 1'b0;
        evMask = 3'h0;
        evMask[hbsl_pkg::IRQ_SENT]   = serDone;
        evMask[hbsl_pkg::IRQ_REQ]    = reqEvent;
        evMask[hbsl_pkg::IRQ_CHANGE] = chgEvent;
        // APB: setup loads the answer, the access edge completes it
        apbAccess = psel && penable && s.pready;
        clrMask   = 3'h0;
        if (psel && !penable) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = 1'b0;
            next_s.prdata  = 32'h0000_0000;
            if (paddr == hbsl_pkg::CTRL_OFS) begin
                next_s.prdata = {29'h0, s.ctrl};
            end else if (paddr == hbsl_pkg::STATUS_OFS) begin
                next_s.prdata = {22'h0, serBusy, s.ovLatched, s.word};
            end else if (paddr == hbsl_pkg::IRQ_STAT_OFS) begin
                next_s.prdata = {29'h0, s.irqStat};
            end else if (paddr == hbsl_pkg::IRQ_MASK_OFS) begin
                next_s.prdata = {29'h0, s.irqMask};
            end else if (paddr == hbsl_pkg::SENT_OFS) begin
                next_s.prdata = {24'h0, s.lastWord};
            end else begin
                next_s.pslverr = 1'b1;
            end
        end else if (apbAccess) begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
            if (pwrite && pstrb[0] && !s.pslverr) begin
                if (paddr == hbsl_pkg::CTRL_OFS) begin
                    next_s.ctrl = pwdata[2:0];
                end else if (paddr == hbsl_pkg::IRQ_MASK_OFS) begin
                    next_s.irqMask = pwdata[2:0];
                end
            end else if (!pwrite && paddr == hbsl_pkg::IRQ_STAT_OFS) begin
                clrMask = s.prdata[2:0];
            end
        end
        // Only bits that were actually read are cleared
        next_s.irqStat = (s.irqStat & ~clrMask) | evMask;
        next_s.irq     = |(next_s.irqStat & next_s.irqMask);
        // Gate outputs: low side active high, high side active low in
        lsOn = lowGateInPhaseA && allow;
        hsOn = !highGateInNPhaseA && allow;
        // Both on would short the bus, so neither is passed
        next_s.gates[0] = lsOn && !hsOn;
        next_s.gates[2] = hsOn && !lsOn;
        lsOn = lowGateInPhaseB && allow;
        hsOn = !highGateInNPhaseB && allow;
        next_s.gates[1] = lsOn && !hsOn;
        next_s.gates[3] = hsOn && !lsOn;
        next_s.lineOut  = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s             <= '0;
            s.ctrl        <= hbsl_pkg::CTRL_RST;
            s.irqMask     <= hbsl_pkg::IRQ_MASK_RST;
            // Report once after power-up
            s.sendPending <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata           = s.prdata;
    assign pready           = s.pready;
    assign pslverr          = s.pslverr;
    assign irq              = s.irq;
    assign lowGateOnPhaseA  = s.gates[0];
    assign lowGateOnPhaseB  = s.gates[1];
    assign highGateOnPhaseA = s.gates[2];
    assign highGateOnPhaseB = s.gates[3];
    assign faultLineOut     = s.lineOut;
    assign faultLineOe      = serOe;

    // ==============================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence ovSeen;
        busOvAbove;
    endsequence

    sequence ovHeld;
        s.ovLatched && !busOvBelowHyst;
    endsequence

    sequence frameBegin;
        serStart ##1 faultLineOe;
    endsequence

    a_ov_stops_gates: assert property (
        ovSeen |=> s.ovLatched ##1 (s.gates == 4'h0))
        else $error("gates still on after overvoltage");

    a_ov_hyst_hold: assert property (
        ovHeld |=> s.ovLatched)
        else $error("overvoltage released above hysteresis");

    a_ov_code: assert property (
        s.ovLatched |=> (s.word[2:0] == hbsl_pkg::CODE_OV))
        else $error("overvoltage code wrong");

    a_ls_not_ready: assert property (
        (!s.ovLatched && trimFault)
        |=> (s.word[2:0] == hbsl_pkg::CODE_LS_NRDY))
        else $error("low-side not ready code wrong");

    a_hs_not_ready: assert property (
        highSideCommLoss |=> (s.word[4:3] == hbsl_pkg::CODE_HS_NRDY))
        else $error("high-side not ready code wrong");

    a_therm_warn: assert property (
        (lowSideThermWarn && !lowSideThermShut && !highSideCommLoss
         && !highSideBypassSupplyFault && !highSideSupplyPinFault)
        |=> (s.word[4:3] == hbsl_pkg::CODE_WARN))
        else $error("thermal warning code wrong");

    a_sense_report: assert property (
        (systemSenseIn && !s.ovLatched && !lowSideSupplyPinFault
         && !senseShortFault && !trimFault)
        |=> (s.word[2:0] == hbsl_pkg::CODE_SYS_OT))
        else $error("system sense not reported");

    a_oc_flags: assert property (
        ##1 (s.word[6:5] == $past({highSideOverCurrent, lowSideOverCurrent})))
        else $error("over-current flags wrong");

    a_parity_bit: assert property (
        $changed(s.word) |-> (s.word[7] == (PARITY_ODD ^ (^s.word[6:0]))))
        else $error("parity bit wrong");

    a_ready_word: assert property (
        (!busOvAbove && !s.ovLatched && busUndervoltage == 4'h0
         && !systemSenseIn && !lowSideSupplyPinFault && !senseShortFault
         && !trimFault && !highSideCommLoss && !highSideBypassSupplyFault
         && !highSideSupplyPinFault && !lowSideThermWarn
         && !lowSideThermShut && !lowSideOverCurrent
         && !highSideOverCurrent) |=> (s.word == {PARITY_ODD, 7'h00}))
        else $error("ready word not all zero");

    a_frame_length: assert property (
        frameBegin |-> ##[388:420] serDone)
        else $error("frame length wrong");

    a_line_pull_only: assert property (
        faultLineOe |-> (faultLineOut == 1'b0))
        else $error("status line driven high");

endmodule : hbsl_status_link
`default_nettype wire

// ---- src/hbsl_pkg.sv ----
// Constants and types of the half-bridge status word link
package hbsl_pkg;

    // ==============================================================
    // Register map
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h0C;
    localparam logic [7:0] SENT_OFS      = 8'h10;

    localparam int         CTRL_LINK_EN  = 0;
    localparam int         CTRL_FORCE    = 1;
    localparam int         CTRL_SW_EN    = 2;
    localparam logic [2:0] CTRL_RST      = 3'h5;

    localparam int         IRQ_SENT      = 0;
    localparam int         IRQ_REQ       = 1;
    localparam int         IRQ_CHANGE    = 2;
    localparam logic [2:0] IRQ_MASK_RST  = 3'h0;

    // ==============================================================
    // Status word fields, held as {bit2,bit1,bit0} and {bit4,bit3}
    localparam logic [2:0] CODE_NONE     = 3'h0;
    localparam logic [2:0] CODE_OV       = 3'h4;
    localparam logic [2:0] CODE_UV100    = 3'h2;
    localparam logic [2:0] CODE_UV85     = 3'h6;
    localparam logic [2:0] CODE_UV70     = 3'h1;
    localparam logic [2:0] CODE_UV55     = 3'h5;
    localparam logic [2:0] CODE_SYS_OT   = 3'h3;
    localparam logic [2:0] CODE_LS_NRDY  = 3'h7;
    localparam logic [1:0] CODE_WARN     = 2'h2;
    localparam logic [1:0] CODE_SHUT     = 2'h1;
    localparam logic [1:0] CODE_HS_NRDY  = 2'h3;
    localparam int         BIT_LS_OC     = 5;
    localparam int         BIT_HS_OC     = 6;

    // ==============================================================
    // Line timing
    localparam int         CLK_PERIOD_NS = 25;
    localparam int         TICK_NS       = 250;
    localparam int         TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_CNT_MAX  = 7'(TICK_CYC - 1);
    localparam logic [3:0] START_TICKS   = 4'h8;
    localparam logic [3:0] SLOT_TICKS    = 4'h4;
    localparam logic [3:0] ONE_LOW       = 4'h1;
    localparam logic [3:0] ZERO_LOW      = 4'h3;
    localparam logic [3:0] REQ_TICKS     = 4'h8;
    localparam logic [2:0] LAST_BIT      = 3'h7;

    typedef enum logic [1:0] {SER_IDLE, SER_START, SER_BITS} hbsl_ser_e;

endpackage : hbsl_pkg

// ---- src/hbsl_word_tx.sv ----
// Pulse-width serialiser for one status frame on the open-drain line
`timescale 1ns/1ps
`default_nettype none
module hbsl_word_tx (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Frame request
    input  wire logic       tick,
    input  wire logic       start,
    input  wire logic [7:0] frame,
    // Line drive and status
    output logic            lineOe,
    output logic            busy,
    output logic            done
);

    typedef struct packed {
        hbsl_pkg::hbsl_ser_e st;
        logic [3:0]          cnt;
        logic [2:0]          idx;
        logic [7:0]          sh;
        logic                oe;
        logic                done;
    } hbsl_tx_s;

    hbsl_tx_s s;
    hbsl_tx_s next_s;

    // ==============================================================
    // Start pulse, then one slot per bit, bit 0 first
    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        case (s.st)
            hbsl_pkg::SER_IDLE: begin
                if (start) begin
                    next_s.st  = hbsl_pkg::SER_START;
                    next_s.sh  = frame;
                    next_s.cnt = 4'h0;
                    next_s.oe  = 1'b1;
                end
            end
            hbsl_pkg::SER_START: begin
                if (tick) begin
                    if (s.cnt == hbsl_pkg::START_TICKS - 4'h1) begin
                        next_s.st  = hbsl_pkg::SER_BITS;
                        next_s.cnt = 4'h0;
                        next_s.idx = 3'h0;
                        next_s.oe  = 1'b0;
                    end else begin
                        next_s.cnt = s.cnt + 4'h1;
                    end
                end
            end
            hbsl_pkg::SER_BITS: begin
                if (tick) begin
                    if (s.cnt == hbsl_pkg::SLOT_TICKS - 4'h1) begin
                        next_s.cnt = 4'h0;
                        next_s.oe  = 1'b0;
                        if (s.idx == hbsl_pkg::LAST_BIT) begin
                            next_s.st   = hbsl_pkg::SER_IDLE;
                            next_s.done = 1'b1;
                        end else begin
                            next_s.idx = s.idx + 3'h1;
                            next_s.sh  = {1'b0, s.sh[7:1]};
                        end
                    end else begin
                        // A one is a short low, a zero a long low
                        next_s.cnt = s.cnt + 4'h1;
                        next_s.oe  = (s.cnt + 4'h1) <= (s.sh[0] ?
                                     hbsl_pkg::ONE_LOW : hbsl_pkg::ZERO_LOW);
                    end
                end
            end
            default: next_s = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign lineOe = s.oe;
    assign busy   = (s.st != hbsl_pkg::SER_IDLE);
    assign done   = s.done;

endmodule : hbsl_word_tx
`default_nettype wire

// ---- bench/hbsl_host_model.sv ----
// Controller model: gate drive, request pulse and frame decoder
`timescale 1ns/1ps
`default_nettype none
module hbsl_host_model (
    // Clock and line
    input  wire logic       ref_clk,
    input  wire logic       lineIn,
    input  wire logic       reqStart,
    output logic            lineOe,
    // Gate intent per phase, active high
    input  wire logic [1:0] lowOn,
    input  wire logic [1:0] highOn,
    output logic [1:0]      lowGateIn,
    output logic [1:0]      highGateInN,
    // Decoded frames
    output logic [7:0]      word,
    output int              frames
);
    // ==========
    // Drive side
    int         reqCnt = 0;
    int         lowLen = 0;
    int         nBit   = -1;
    logic [7:0] sh     = 8'h00;
    assign lowGateIn   = lowOn;
    assign highGateInN = ~highOn;
    assign lineOe      = (reqCnt != 0);
    initial word = 8'h00;
    initial frames = 0;
    // Request pulse is longer than eight ticks
    always @(posedge ref_clk) begin
        if (reqStart && reqCnt == 0) reqCnt <= 100;
        else if (reqCnt != 0) reqCnt <= reqCnt - 1;
    end
    // Long low is a start, short low a one; bit 0 comes first
    always @(posedge ref_clk) begin
        if (!lineIn) lowLen <= lowLen + 1;
        else if (lowLen != 0) begin
            lowLen <= 0;
            if (lowLen >= 60) nBit <= 0;
            else if (nBit == 7) begin
                word   <= {lowLen < 20, sh[7:1]};
                frames <= frames + 1;
                nBit   <= -1;
            end else if (nBit >= 0) begin
                sh   <= {lowLen < 20, sh[7:1]};
                nBit <= nBit + 1;
            end
        end
    end
endmodule : hbsl_host_model
`default_nettype wire

// ---- bench/hbsl_status_link_test.sv ----
// Self-checking bench for the status word link
`timescale 1ns/1ps
`default_nettype none
module hbsl_status_link_test;
    logic        refClk = 1'b0;
    logic        rstN   = 1'b0;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        ovUp   = 1'b0;
    logic        ovDown = 1'b1;
    logic        reqGo  = 1'b0;
    logic [3:0]  uv     = 4'h0;
    logic [10:0] flt    = 11'h000;
    logic [1:0]  lowOn  = 2'h0;
    logic [1:0]  highOn = 2'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, devOe, devOut, hostOe, err;
    logic [1:0]  lowIn, highInN, lowOut, highOut;
    logic [7:0]  word;
    logic [7:0]  prev = 8'hFF;
    logic        ovL  = 1'b0;
    int          frames, nMismatch = 0, checkCount = 0;
    wire logic   line = ~(devOe | hostOe);
    always #12.5 refClk = ~refClk;
    hbsl_status_link u_hbsl_status_link (
        .ref_clk(refClk), .rst_n(rstN), .psel(psel), .penable(pen),
        .pwrite(pwr), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .busOvAbove(ovUp), .busOvBelowHyst(ovDown), .busUndervoltage(uv),
        .systemSenseIn(flt[0]), .lowSideSupplyPinFault(flt[1]),
        .senseShortFault(flt[2]), .trimFault(flt[3]),
        .highSideCommLoss(flt[4]), .highSideBypassSupplyFault(flt[5]),
        .highSideSupplyPinFault(flt[6]), .lowSideThermWarn(flt[7]),
        .lowSideThermShut(flt[8]), .lowSideOverCurrent(flt[9]),
        .highSideOverCurrent(flt[10]), .lowGateInPhaseA(lowIn[0]),
        .lowGateInPhaseB(lowIn[1]), .highGateInNPhaseA(highInN[0]),
        .highGateInNPhaseB(highInN[1]), .lowGateOnPhaseA(lowOut[0]),
        .lowGateOnPhaseB(lowOut[1]), .highGateOnPhaseA(highOut[0]),
        .highGateOnPhaseB(highOut[1]), .faultLineIn(line),
        .faultLineOut(devOut), .faultLineOe(devOe));
    hbsl_host_model u_hbsl_host_model (
        .ref_clk(refClk), .lineIn(line), .reqStart(reqGo), .lineOe(hostOe),
        .lowOn(lowOn), .highOn(highOn), .lowGateIn(lowIn),
        .highGateInN(highInN), .word(word), .frames(frames));
    // ==========
    // Helpers
    task automatic conclude();
        if (nMismatch == 0 && checkCount > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checkCount++;
        if (g !== e) begin
            nMismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge refClk);
        pen <= 1'b1;
        do begin
            @(posedge refClk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd   = prdata;
        err  = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge refClk);
        if (n >= 50) chk(32'h0, 32'h1, "apb hang");
    endtask : apb
    function automatic logic [7:0] expWord(input logic o,
            input logic [3:0] u, input logic [10:0] f);
        logic [7:0] w;
        w = 8'h00;
        if (o) w[2:0] = 3'h4;
        else if (|f[3:1]) w[2:0] = 3'h7;
        else if (f[0]) w[2:0] = 3'h3;
        else if (u[3]) w[2:0] = 3'h5;
        else if (u[2]) w[2:0] = 3'h1;
        else if (u[1]) w[2:0] = 3'h6;
        else if (u[0]) w[2:0] = 3'h2;
        if (|f[6:4]) w[4:3] = 2'h3;
        else if (f[8]) w[4:3] = 2'h1;
        else if (f[7]) w[4:3] = 2'h2;
        w[6:5] = f[10:9];
        w[7] = ^w[6:0];
        return w;
    endfunction : expWord
    task automatic waitFrame(input logic [7:0] e);
        int f0, n;
        f0 = frames;
        n  = 0;
        while (frames == f0 && n < 3000) begin
            @(posedge refClk);
            n++;
        end
        // A missing frame must not pass on a stale word
        if (n >= 3000) chk(32'h0, 32'h1, "frame timeout");
        chk(word, e, "line word");
        // Sent flag lands once the last slot of 40 cycles is over
        repeat (40) @(posedge refClk);
    endtask : waitFrame
    task automatic settle();
        logic [7:0] e;
        e = expWord(ovL, uv, flt);
        if (e !== prev) begin
            waitFrame(e);
            chk(irq, 1'b1, "irq raised");
            apb(1'b0, 8'h08, 32'h0);
            chk(rd[0], 1'b1, "sent flag");
            repeat (2) @(posedge refClk);
            chk(irq, 1'b0, "irq cleared");
        end
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[8:0], {ovL, e}, "status reg");
        prev = e;
    endtask : settle
    // ==========
    // Scenarios
    initial begin
        void'($urandom(32'hA062));
        repeat (16) @(posedge refClk);
        rstN <= 1'b1;
        @(posedge refClk);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h5, "ctrl reset");
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0, "mask reset");
        apb(1'b0, 8'h20, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped");
        apb(1'b1, 8'h04, 32'hFF);
        apb(1'b1, 8'h0C, 32'h1);
        settle();
        for (int i = 0; i < 28; i++) begin
            if (i < 11) flt <= 11'(1 << i);
            else if (i < 15) begin
                flt <= 11'h000;
                uv  <= 4'(1 << (i - 11));
            end else if (i < 27) begin
                flt <= 11'($urandom & $urandom);
                uv  <= 4'($urandom);
            end else begin
                flt <= 11'h000;
                uv  <= 4'h0;
            end
            @(posedge refClk);
            settle();
        end
        for (int m = 0; m < 4; m++) begin
            if (m == 1) apb(1'b1, 8'h00, 32'h1);
            if (m == 2) begin
                apb(1'b1, 8'h00, 32'h5);
                ovDown <= 1'b0;
                ovUp   <= 1'b1;
                @(posedge refClk);
                ovUp <= 1'b0;
                ovL = 1'b1;
                settle();
            end
            if (m == 3) begin
                ovDown <= 1'b1;
                ovL = 1'b0;
                @(posedge refClk);
                settle();
            end
            for (int k = 0; k < 6; k++) begin
                lowOn  <= 2'($urandom);
                highOn <= 2'($urandom);
                repeat (3) @(posedge refClk);
                chk(lowOut, lowOn & ~highOn & {2{m != 1 && m != 2}},
                    "low gate");
                chk(highOut, highOn & ~lowOn & {2{m != 1 && m != 2}},
                    "high gate");
            end
        end
        apb(1'b1, 8'h0C, 32'h0);
        reqGo <= 1'b1;
        @(posedge refClk);
        reqGo <= 1'b0;
        waitFrame(8'h00);
        apb(1'b0, 8'h08, 32'h0);
        chk({irq, rd[2:0]}, 4'h3, "masked request");
        chk(devOut, 1'b0, "pull low only");
        // Link off holds every send; force queues one more
        apb(1'b1, 8'h00, 32'h6);
        flt <= 11'h001;
        repeat (500) @(posedge refClk);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd[0], 1'b0, "link off held frame");
        apb(1'b1, 8'h00, 32'h5);
        waitFrame(expWord(1'b0, 4'h0, 11'h001));
        apb(1'b1, 8'h00, 32'h7);
        waitFrame(expWord(1'b0, 4'h0, 11'h001));
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h5, "force self clear");
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, {24'h0, expWord(1'b0, 4'h0, 11'h001)}, "sent word");
        conclude();
    end
    initial begin
        repeat (100000) @(posedge refClk);
        nMismatch++;
        conclude();
    end
endmodule : hbsl_status_link_test
`default_nettype wire
